// [rtl/frame_checker_statistics.sv]
`timescale 1ns/1ns
`default_nettype none

module frame_checker_statistics
  import fc_stats_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register port.
  input wire reg_req_t reg_req,
  output logic [15:0] rd_data_q,
  // Frame status taps.
  input wire frame_tap_t mac_tap,
  input wire frame_tap_t phy_tap,
  // Interrupt.
  output logic irq_q
);

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  logic enable_q;
  logic irq_en_q;
  logic side_q;
  logic diag_mask_q;
  logic diag_status_q;
  logic sym_seen_q;
  logic [31:0] frame_cnt_q;
  logic [15:0] crc_cnt_q;
  logic [15:0] len_cnt_q;
  logic [15:0] align_cnt_q;
  logic [15:0] sym_cnt_q;
  logic [15:0] rx_err_q;
  logic [31:0] frame_copy_q;
  logic [15:0] len_copy_q;
  logic [15:0] align_copy_q;
  logic [15:0] sym_copy_q;
  frame_tap_t tap;
  logic frame_done;
  logic sym_frame;
  logic err_evt;
  logic rd_err;
  logic rd_status;
  logic wr_status_clr;

  // Path selection.
  assign tap = side_q ? mac_tap : phy_tap;
  assign frame_done = enable_q && tap.frame_end;
  assign sym_frame = sym_seen_q || (tap.dv && tap.er);
  assign err_evt = frame_done
    && (tap.crc_err || tap.len_err || tap.align_err || sym_frame);
  assign rd_err = reg_req.rd && hit(reg_req.addr, OFF_RX_ERROR_TOTAL);
  assign rd_status = reg_req.rd && hit(reg_req.addr, OFF_SUBSYS_IRQ_STATUS);
  assign wr_status_clr = reg_req.wr && hit(reg_req.addr, OFF_SUBSYS_IRQ_STATUS)
    && reg_req.wdata[DIAG_IRQ_BIT];

  // Control registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable_q <= CHECKER_ENABLE_RST;
      irq_en_q <= CHECKER_IRQ_ENABLE_RST;
      side_q <= CHECK_SIDE_SELECT_RST;
      diag_mask_q <= DIAG_IRQ_MASK_RST;
    end else if (reg_req.wr) begin
      if (hit(reg_req.addr, OFF_CHECKER_ENABLE)) begin
        enable_q <= reg_req.wdata[CTRL_BIT];
      end
      if (hit(reg_req.addr, OFF_CHECKER_IRQ_ENABLE)) begin
        irq_en_q <= reg_req.wdata[CTRL_BIT];
      end
      if (hit(reg_req.addr, OFF_CHECK_SIDE_SELECT)) begin
        side_q <= reg_req.wdata[CTRL_BIT];
      end
      if (hit(reg_req.addr, OFF_SUBSYS_IRQ_MASK)) begin
        diag_mask_q <= reg_req.wdata[DIAG_IRQ_BIT];
      end
    end
  end

  // Symbol error seen somewhere inside the current frame.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sym_seen_q <= 1'b0;
    end else if (frame_done || !enable_q) begin
      sym_seen_q <= 1'b0;
    end else if (tap.dv && tap.er) begin
      sym_seen_q <= 1'b1;
    end
  end

  // Running counters.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_cnt_q <= COUNT32_RST;
      crc_cnt_q <= COUNT16_RST;
      len_cnt_q <= COUNT16_RST;
      align_cnt_q <= COUNT16_RST;
      sym_cnt_q <= COUNT16_RST;
    end else if (frame_done) begin
      frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
      if (tap.crc_err) begin
        crc_cnt_q <= crc_cnt_q + 16'h0001;
      end
      if (tap.len_err) begin
        len_cnt_q <= len_cnt_q + 16'h0001;
      end
      if (tap.align_err) begin
        align_cnt_q <= align_cnt_q + 16'h0001;
      end
      if (sym_frame) begin
        sym_cnt_q <= sym_cnt_q + 16'h0001;
      end
    end
  end

  // Receive error total, cleared by its read; a same-cycle error survives.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_err_q <= COUNT16_RST;
    end else if (rd_err) begin
      rx_err_q <= err_evt ? 16'h0001 : COUNT16_RST;
    end else if (err_evt) begin
      rx_err_q <= rx_err_q + 16'h0001;
    end
  end

  // Copies taken together on the read of the receive error total.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_copy_q <= COUNT32_RST;
      len_copy_q <= COUNT16_RST;
      align_copy_q <= COUNT16_RST;
      sym_copy_q <= COUNT16_RST;
    end else if (rd_err) begin
      frame_copy_q <= frame_cnt_q;
      len_copy_q <= len_cnt_q;
      align_copy_q <= align_cnt_q;
      sym_copy_q <= sym_cnt_q;
    end
  end

  // Subsystem status bit: sticky, cleared by read or write-one, set wins.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diag_status_q <= 1'b0;
    end else if (err_evt && irq_en_q) begin
      diag_status_q <= 1'b1;
    end else if (rd_status || wr_status_clr) begin
      diag_status_q <= 1'b0;
    end
  end

  // Interrupt output.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= diag_status_q && diag_mask_q;
    end
  end

  // Read data, valid in the cycle after the read strobe only.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_q <= COUNT16_RST;
    end else if (!reg_req.rd) begin
      rd_data_q <= COUNT16_RST;
    end else begin
      case (reg_req.addr)
        OFF_SUBSYS_IRQ_STATUS: rd_data_q <= {1'b0, diag_status_q, 14'h0000};
        OFF_SUBSYS_IRQ_MASK: rd_data_q <= {1'b0, diag_mask_q, 14'h0000};
        OFF_CHECKER_ENABLE: rd_data_q <= {15'h0000, enable_q};
        OFF_CHECKER_IRQ_ENABLE: rd_data_q <= {15'h0000, irq_en_q};
        OFF_CHECK_SIDE_SELECT: rd_data_q <= {15'h0000, side_q};
        OFF_RX_ERROR_TOTAL: rd_data_q <= rx_err_q;
        OFF_FRAME_TOTAL_HIGH: rd_data_q <= frame_copy_q[31:16];
        OFF_FRAME_TOTAL_LOW: rd_data_q <= frame_copy_q[15:0];
        OFF_LENGTH_ERROR_TOTAL: rd_data_q <= len_copy_q;
        OFF_ALIGNMENT_ERROR_TOTAL: rd_data_q <= align_copy_q;
        OFF_SYMBOL_ERROR_TOTAL: rd_data_q <= sym_copy_q;
        default: rd_data_q <= COUNT16_RST;
      endcase
    end
  end

  // Checks.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_hold_disabled;
    !enable_q |=> $stable(frame_cnt_q) && $stable(len_cnt_q) && $stable(sym_cnt_q);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("Counters moved while the checker was disabled.");

  property p_frame_count;
    enable_q && tap.frame_end |=> frame_cnt_q == $past(frame_cnt_q) + 32'h0000_0001;
  endproperty
  a_frame_count: assert property (p_frame_count)
    else $error("Frame total did not advance at frame end.");

  property p_side_ignored;
    enable_q && !side_q && mac_tap.frame_end && !phy_tap.frame_end |=> $stable(frame_cnt_q);
  endproperty
  a_side_ignored: assert property (p_side_ignored)
    else $error("Frame counted from the unselected path.");

  property p_err_clear;
    rd_err && !err_evt |=> rx_err_q == 16'h0000;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("Receive error total not cleared by its read.");

  property p_err_read;
    rd_err |=> rd_data_q == $past(rx_err_q);
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("Receive error total read returned the wrong value.");

  property p_frame_copy;
    rd_err |=> frame_copy_q == $past(frame_cnt_q) && len_copy_q == $past(len_cnt_q);
  endproperty
  a_frame_copy: assert property (p_frame_copy)
    else $error("Frame or length copy not taken on the error total read.");

  property p_err_copies;
    rd_err |=> align_copy_q == $past(align_cnt_q) && sym_copy_q == $past(sym_cnt_q);
  endproperty
  a_err_copies: assert property (p_err_copies)
    else $error("Alignment or symbol copy not taken on the error total read.");

  property p_copy_stable;
    !rd_err |=> $stable(frame_copy_q) && $stable(sym_copy_q);
  endproperty
  a_copy_stable: assert property (p_copy_stable)
    else $error("Copy changed without an error total read.");

  property p_sym_count;
    enable_q && tap.frame_end && tap.dv && tap.er |=> sym_cnt_q == $past(sym_cnt_q) + 16'h0001;
  endproperty
  a_sym_count: assert property (p_sym_count)
    else $error("Symbol error frame not counted.");

  property p_event_sets;
    err_evt && irq_en_q |=> diag_status_q;
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("Receive error did not raise the checker event.");

  property p_irq_level;
    diag_status_q && diag_mask_q |=> irq_q;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Unmasked checker event did not raise the interrupt.");

  property p_crc_count;
    enable_q && tap.frame_end && tap.crc_err |=> crc_cnt_q == $past(crc_cnt_q) + 16'h0001;
  endproperty
  a_crc_count: assert property (p_crc_count)
    else $error("CRC error frame not counted.");

  property p_err_count;
    err_evt && !rd_err |=> rx_err_q == $past(rx_err_q) + 16'h0001;
  endproperty
  a_err_count: assert property (p_err_count)
    else $error("Receive error total did not advance on an error frame.");

  property p_len_count;
    enable_q && tap.frame_end && tap.len_err |=> len_cnt_q == $past(len_cnt_q) + 16'h0001;
  endproperty
  a_len_count: assert property (p_len_count)
    else $error("Length error frame not counted.");

  property p_align_count;
    enable_q && tap.frame_end && tap.align_err |=> align_cnt_q == $past(align_cnt_q) + 16'h0001;
  endproperty
  a_align_count: assert property (p_align_count)
    else $error("Alignment error frame not counted.");

  property p_status_holds;
    diag_status_q && !rd_status && !wr_status_clr |=> diag_status_q;
  endproperty
  a_status_holds: assert property (p_status_holds)
    else $error("Status bit dropped without a read or clear.");

  property p_no_event;
    !diag_status_q && !(err_evt && irq_en_q) |=> !diag_status_q;
  endproperty
  a_no_event: assert property (p_no_event)
    else $error("Status bit set without an enabled receive error.");

endmodule

`default_nettype wire

// [rtl/fc_stats_pkg.sv]
package fc_stats_pkg;

  // Register offsets in the 16-bit register space.
  localparam logic [15:0] OFF_SUBSYS_IRQ_STATUS = 16'h0011;
  localparam logic [15:0] OFF_SUBSYS_IRQ_MASK = 16'h0021;
  localparam logic [15:0] OFF_CHECKER_ENABLE = 16'h8001;
  localparam logic [15:0] OFF_CHECKER_IRQ_ENABLE = 16'h8004;
  localparam logic [15:0] OFF_CHECK_SIDE_SELECT = 16'h8005;
  localparam logic [15:0] OFF_RX_ERROR_TOTAL = 16'h8008;
  localparam logic [15:0] OFF_FRAME_TOTAL_HIGH = 16'h8009;
  localparam logic [15:0] OFF_FRAME_TOTAL_LOW = 16'h800a;
  localparam logic [15:0] OFF_LENGTH_ERROR_TOTAL = 16'h800b;
  localparam logic [15:0] OFF_ALIGNMENT_ERROR_TOTAL = 16'h800c;
  localparam logic [15:0] OFF_SYMBOL_ERROR_TOTAL = 16'h800d;

  // Field positions.
  localparam int unsigned CTRL_BIT = 0;
  localparam int unsigned DIAG_IRQ_BIT = 14;

  // Reset values.
  localparam logic CHECKER_ENABLE_RST = 1'b1;
  localparam logic CHECKER_IRQ_ENABLE_RST = 1'b1;
  localparam logic CHECK_SIDE_SELECT_RST = 1'b0;
  localparam logic DIAG_IRQ_MASK_RST = 1'b0;
  localparam logic [15:0] COUNT16_RST = 16'h0000;
  localparam logic [31:0] COUNT32_RST = 32'h0000_0000;

  // Register port request, all fields valid in one cycle.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Per-path frame status from the MII-side logic on the same clock.
  typedef struct packed {
    logic dv;
    logic er;
    logic frame_end;
    logic crc_err;
    logic len_err;
    logic align_err;
  } frame_tap_t;

endpackage

// [dv/frame_tap_model.sv]
`timescale 1ns/1ns
`default_nettype none

module frame_tap_model
  import fc_stats_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Frame request from the bench.
  input wire logic go,
  input wire logic [3:0] kind,
  // Frame status toward the checker.
  output frame_tap_t tap
);
  logic [1:0] step_q;
  logic [3:0] kind_q;

  // A frame is two data cycles; the error flags stay stale outside the end cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_q <= 2'h0;
      kind_q <= 4'h0;
    end else if (go) begin
      step_q <= 2'h1;
      kind_q <= kind;
    end else if (step_q != 2'h0) begin
      step_q <= (step_q == 2'h2) ? 2'h0 : step_q + 2'h1;
    end
  end

  assign tap.dv = (step_q != 2'h0);
  // With the CRC flag too, the symbol error also stands in the end cycle.
  assign tap.er = ((step_q == 2'h1) || (step_q == 2'h2 && kind_q[0])) && kind_q[3];
  assign tap.frame_end = (step_q == 2'h2);
  assign tap.crc_err = kind_q[0];
  assign tap.len_err = kind_q[1];
  assign tap.align_err = kind_q[2];
endmodule

`default_nettype wire

// [dv/frame_checker_statistics_bench.sv]
`timescale 1ns/1ns
`default_nettype none

module frame_checker_statistics_bench
  import fc_stats_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  logic go_mac = 1'b0;
  logic go_phy = 1'b0;
  logic [3:0] kind = 4'h0;
  logic [15:0] rd_data_q;
  logic irq_q;
  frame_tap_t mac_tap;
  frame_tap_t phy_tap;
  int miscompares = 0;
  int checked = 0;

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  frame_checker_statistics frame_checker_statistics_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_req(req), .rd_data_q(rd_data_q),
    .mac_tap(mac_tap), .phy_tap(phy_tap), .irq_q(irq_q));
  frame_tap_model frame_tap_model_mac_inst (
    .clk_sys(clk_sys), .rst(rst), .go(go_mac), .kind(kind), .tap(mac_tap));
  frame_tap_model frame_tap_model_phy_inst (
    .clk_sys(clk_sys), .rst(rst), .go(go_phy), .kind(kind), .tap(phy_tap));

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask

  // Reads a register and compares the data in the cycle after the strobe.
  task automatic rc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    chk16($sformatf("reg %h", a), exp, rd_data_q);
  endtask

  task automatic send(input logic mac, input logic [3:0] k);
    @(posedge clk_sys);
    kind <= k;
    go_mac <= mac;
    go_phy <= ~mac;
    @(posedge clk_sys);
    go_mac <= 1'b0;
    go_phy <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    end_sim;
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rc(16'h8001, 16'h0001);
    rc(16'h8004, 16'h0001);
    rc(16'h8005, 16'h0000);
    rc(16'h0021, 16'h0000);
    rc(16'h8002, 16'h0000);
    for (int a = 16'h8008; a <= 16'h800d; a++) begin
      rc(a[15:0], 16'h0000);
    end
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      send(1'b0, 4'((1 << i) >> 1));
    end
    send(1'b1, 4'h1);
    chk1("irq masked", 1'b0, irq_q);
    rc(16'h0011, 16'h4000);
    rc(16'h0011, 16'h0000);
    rc(16'h8008, 16'h0004);
    rc(16'h8008, 16'h0000);
    rc(16'h8009, 16'h0000);
    rc(16'h800a, 16'h0005);
    rc(16'h800b, 16'h0001);
    rc(16'h800c, 16'h0001);
    rc(16'h800d, 16'h0001);
    $display("test error counts done");
    wr_reg(16'h0021, 16'h4000);
    rc(16'h0021, 16'h4000);
    send(1'b0, 4'h1);
    chk1("irq raised", 1'b1, irq_q);
    rc(16'h0011, 16'h4000);
    #4;
    chk1("irq cleared", 1'b0, irq_q);
    wr_reg(16'h8004, 16'h0000);
    send(1'b0, 4'h1);
    chk1("irq disabled", 1'b0, irq_q);
    rc(16'h0011, 16'h0000);
    wr_reg(16'h8004, 16'h0001);
    send(1'b0, 4'h9);
    chk1("irq raised again", 1'b1, irq_q);
    wr_reg(16'h0011, 16'h4000);
    rc(16'h0011, 16'h0000);
    chk1("irq after write clear", 1'b0, irq_q);
    $display("test interrupt done");
    wr_reg(16'h8005, 16'h0001);
    send(1'b0, 4'h1);
    send(1'b1, 4'h2);
    wr_reg(16'h8001, 16'h0000);
    send(1'b1, 4'h8);
    wr_reg(16'h800a, 16'hffff);
    rc(16'h8008, 16'h0004);
    rc(16'h800a, 16'h0009);
    rc(16'h800b, 16'h0002);
    rc(16'h800d, 16'h0002);
    rc(16'h8001, 16'h0000);
    rc(16'h8005, 16'h0001);
    $display("test side select and disable done");
    end_sim;
  end
endmodule

`default_nettype wire
